// ==== dv/mcdll_fb_model.sv ====
// Feedback trace and board reset model for the memory clock DLL
`timescale 1ns/1ps
`default_nettype none
module mcdll_fb_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [6:0] tap_select,
    input  wire logic [7:0] target,
    input  wire logic       slow,
    input  wire logic       pll_locked,
    output logic            fb_early,
    output logic            core_hard_reset_n,
    output logic            peripheral_hard_reset_n
);
    logic [3:0] lag;
    int         hold;
    logic       early;
    // Clock is early while the tap is short of the loop delay
    assign early = {1'b0, tap_select} < target;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lag <= '0;
            hold <= 0;
        end
        else
        begin
            lag <= {lag[2:0], early};
            if (pll_locked && hold < 255)
                hold <= hold + 1;
        end
    end
    // Long trace: comparator sees a stale phase
    assign fb_early = slow ? lag[3] : early;
    assign core_hard_reset_n = (hold == 255);
    assign peripheral_hard_reset_n = core_hard_reset_n;
endmodule
`default_nettype wire

// ==== dv/test_mcdll_top.sv ====
// Self-checking bench for the memory clock DLL controller
`timescale 1ns/1ps
`default_nettype none
module test_mcdll_top
    import mcdll_pkg::*;
;
    localparam int unsigned LCK = 20;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, se, pll_enable = 0, ratio = 0, slow = 0;
    logic        fb_early, spc, ext, dll_locked, pll_locked, ref_en, mem_en;
    logic        hrst_n, hrst2_n;
    logic [6:0]  tap_select;
    logic [7:0]  target = 8'h28, p, s;
    int          err_count = 0, n_compared = 0, n, t0, t1;
    int          regm [int];

    mcdll_top #(.PLL_LOCK_CYC(LCK)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fb_early(fb_early), .pll_enable(pll_enable),
        .mem_ratio_2to1(ratio), .tap_select(tap_select),
        .tap_spacing_max(spc), .dll_extend(ext), .dll_locked(dll_locked),
        .pll_locked(pll_locked), .ref_clk_en(ref_en), .mem_clk_en(mem_en));
    mcdll_fb_model fb (.pclk(pclk), .presetn(presetn), .tap_select(tap_select),
        .target(target), .slow(slow), .pll_locked(pll_locked),
        .fb_early(fb_early), .core_hard_reset_n(hrst_n),
        .peripheral_hard_reset_n(hrst2_n));

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Idle cycle at the end keeps back-to-back calls free of double drives
    task automatic apb(logic wr, logic [7:0] idx, logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
        chk("pready", pready, 1);
        rd = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(string nm, logic [7:0] idx, logic [31:0] e, logic x);
        apb(0, idx, '0);
        chk(nm, rd, e);
        chk("pslverr", se, x);
    endtask

    task automatic pll_on();
        n = 0;
        pll_enable <= 1;
        do @(posedge pclk); while (pll_locked !== 1'b1 && ++n < 200);
        chk("lock time", n >= LCK && n <= LCK + 10, 1);
    endtask

    task automatic clk_cnt(int em);
        int r;
        int m;
        r = 0;
        m = 0;
        repeat (40)
        begin
            @(posedge pclk);
            r += ref_en;
            m += mem_en;
        end
        chk("ref edges", r, 10);
        chk("mem edges", m, em);
    endtask

    task automatic lock_chk(logic [7:0] tg, int tol);
        int lo;
        int hi;
        lo = 200;
        hi = 0;
        n = 0;
        target <= tg;
        do @(posedge pclk); while (dll_locked !== 1'b1 && ++n < 2000);
        chk("dll lock", dll_locked, 1);
        repeat (40) @(posedge pclk);
        for (int i = 0; i < 12; i++)
        begin
            apb(0, IDX_TAP_POS, '0);
            chk("tap bit7", rd[31:7], 0);
            chk("tap near", int'(rd) > tg - tol && int'(rd) < tg + tol, 1);
            lo = int'(rd) < lo ? int'(rd) : lo;
            hi = int'(rd) > hi ? int'(rd) : hi;
        end
        chk("tap moves", hi > lo, 1);
    endtask

    task automatic tap_wait(logic [6:0] v);
        n = 0;
        do @(posedge pclk); while (tap_select !== v && ++n < 800);
        chk("tap reach", tap_select, v);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial
    begin
        void'($urandom(78294));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk("ext rst", ext, 0);
        chk("spc rst", spc, 0);
        rd_chk("pmc two", IDX_PMC_TWO, PMC_TWO_RST, 0);
        rd_chk("spacing", IDX_SPACING, SPACING_RST, 0);
        rd_chk("tap off", IDX_TAP_POS, 0, 0);
        rd_chk("unmapped", 8'h10, 0, 1);
        apb(1, IDX_TAP_POS, 32'h0000_007F);
        chk("ro write", se, 1);
        rd_chk("tap kept", IDX_TAP_POS, 0, 0);
        for (int m = 0; m < 4; m++)
        begin
            p = 8'($urandom);
            s = 8'($urandom);
            p[EXTEND_BIT] = m[0];
            s[MAX_DELAY_BIT] = m[1];
            regm[IDX_PMC_TWO] = p;
            regm[IDX_SPACING] = s;
            apb(1, IDX_PMC_TWO, {24'($urandom), p});
            apb(1, IDX_SPACING, {24'($urandom), s});
            rd_chk("pmc two", IDX_PMC_TWO, regm[IDX_PMC_TWO], 0);
            rd_chk("spacing", IDX_SPACING, regm[IDX_SPACING], 0);
            chk("extend", ext, m[0]);
            chk("max dly", spc, m[1]);
        end
        apb(1, IDX_PMC_TWO, 0);
        apb(1, IDX_SPACING, 0);
        pll_on();
        chk("core rst hold", hrst_n, 0);
        chk("ctrl rst hold", hrst2_n, 0);
        clk_cnt(10);
        lock_chk(8'h28, 3);
        t0 = int'(rd);
        apb(1, IDX_PMC_TWO, 32'h0000_0080);
        @(posedge pclk);
        chk("relock clr", dll_locked, 0);
        chk("tap restart", tap_select, TAP_MIN);
        slow <= 1;
        lock_chk(8'h14, 6);
        t1 = int'(rd);
        chk("pick mode", t1 < t0, 1);
        chk("tap floor", t1 >= 12, 1);
        chk("core rst free", hrst_n, 1);
        chk("ctrl rst free", hrst2_n, 1);
        target <= 8'hFF;
        tap_wait(TAP_MAX);
        tap_wait(TAP_MIN);
        apb(1, IDX_PMC_TWO, 0);
        tap_wait(TAP_MAX);
        repeat (40) @(posedge pclk);
        chk("tap sat", tap_select, TAP_MAX);
        chk("no rev", dll_locked, 0);
        pll_enable <= 0;
        repeat (10) @(posedge pclk);
        chk("pll off", pll_locked, 0);
        ratio <= 1;
        pll_on();
        clk_cnt(20);
        apb(0, IDX_STATUS, '0);
        chk("status", rd & 32'h0000_0005, 32'h0000_0005);
        complete_run();
    end

    initial
    begin
        #200_000;
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire

// ==== src/mcdll_pkg.sv ====
// Constants and state types for the memory clock DLL block
package mcdll_pkg;

    // ****************************************************
    // Clock and timing
    // ****************************************************
    localparam int unsigned PCLK_PERIOD_NS  = 10;
    localparam int unsigned PLL_LOCK_US     = 100;
    localparam int unsigned PLL_LOCK_CYCLES =
        (PLL_LOCK_US * 1000) / PCLK_PERIOD_NS;
    localparam int unsigned LOCK_CNT_W      = 14;

    // Reference clock phase: four pclk per reference period
    localparam logic [1:0]  REF_PHASE_LAST  = 2'h3;
    localparam logic [1:0]  REF_PHASE_MID   = 2'h1;
    localparam logic [1:0]  REF_PHASE_STEP  = 2'h1;

    // ****************************************************
    // Register indices (byte address is four times these)
    // ****************************************************
    localparam logic [7:0]  IDX_PMC_TWO     = 8'h72;
    localparam logic [7:0]  IDX_SPACING     = 8'h76;
    localparam logic [7:0]  IDX_TAP_POS     = 8'hE3;
    localparam logic [7:0]  IDX_STATUS      = 8'hE4;

    // ****************************************************
    // Fields and reset values
    // ****************************************************
    localparam int unsigned EXTEND_BIT      = 7;
    localparam int unsigned MAX_DELAY_BIT   = 2;
    localparam int unsigned STS_PLL_BIT     = 0;
    localparam int unsigned STS_DLL_BIT     = 1;
    localparam int unsigned STS_RATIO_BIT   = 2;
    localparam logic [7:0]  PMC_TWO_RST     = 8'h00;
    localparam logic [7:0]  SPACING_RST     = 8'h00;
    localparam logic [6:0]  TAP_MAX         = 7'h7F;
    localparam logic [6:0]  TAP_MIN         = 7'h00;
    localparam logic [6:0]  TAP_STEP        = 7'h01;

    // ****************************************************
    // Input synchroniser lanes
    // ****************************************************
    localparam int unsigned SYNC_W          = 3;
    localparam int unsigned LANE_FB         = 0;
    localparam int unsigned LANE_PLL_EN     = 1;
    localparam int unsigned LANE_RATIO      = 2;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] out;
    } mcdll_sync_st_t;

    typedef struct packed {
        logic [LOCK_CNT_W-1:0] cnt;
        logic                  locked;
    } mcdll_pll_st_t;

    typedef struct packed {
        logic [7:0] pmc_two;
        logic [7:0] spacing;
        logic [7:0] rdata;
        logic       pready;
        logic       pslverr;
        logic [6:0] tap;
        logic       dir_up;
        logic       locked;
        logic [1:0] mode_prev;
        logic       ratio;
        logic [1:0] phase;
        logic       ref_en;
        logic       mem_en;
    } mcdll_top_st_t;

endpackage

// ==== src/mcdll_pll_timer.sv ====
// PLL lock interval timer
`timescale 1ns/1ps
`default_nettype none
module mcdll_pll_timer
    import mcdll_pkg::*;
#(
    parameter int unsigned LOCK_CYC = PLL_LOCK_CYCLES
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pll_enable,
    output logic      pll_locked
);

    localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CYC[LOCK_CNT_W-1:0];

    mcdll_pll_st_t st_r;
    mcdll_pll_st_t st_nxt;

    // ****************************************************
    // Lock timer
    // ****************************************************
    // Sleep disable drops lock; re-enable restarts the full wait
    always_comb
    begin
        st_nxt = st_r;
        if (!pll_enable)
        begin
            st_nxt.cnt    = '0;
            st_nxt.locked = 1'b0;
        end
        else if (st_r.cnt == LOCK_LAST)
            st_nxt.locked = 1'b1;
        else
            st_nxt.cnt = st_r.cnt + {{(LOCK_CNT_W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign pll_locked = st_r.locked;

    lock_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        pll_enable && !st_r.locked |-> st_r.cnt <= LOCK_LAST)
        else $error("pll lock wait overran its bound");

endmodule
`default_nettype wire

// ==== src/mcdll_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mcdll_sync
    import mcdll_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [SYNC_W-1:0] pins_in,
    output logic      [SYNC_W-1:0] pins_sync
);

    mcdll_sync_st_t    st_r;
    mcdll_sync_st_t    st_nxt;
    logic [SYNC_W-1:0] agreed;

    // ****************************************************
    // Per lane filter
    // ****************************************************
    // Stage one feeds only stage two; a change counts once two and
    // three agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_lane
            assign agreed[gi] = (st_r.s2[gi] == st_r.s3[gi]) ?
                                st_r.s3[gi] : st_r.out[gi];
        end
    endgenerate

    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.s1  = pins_in;
        st_nxt.s2  = st_r.s1;
        st_nxt.s3  = st_r.s2;
        st_nxt.out = agreed;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign pins_sync = st_r.out;

endmodule
`default_nettype wire

// ==== src/mcdll_top.sv ====
// Memory clock DLL controller with APB registers and PLL lock timer
//
// Operation
// - Two bits select one of four modes
// - 128 taps; max-delay bit widens tap spacing
// - Tap position readable, bits 6..0, read-only
// - Reported tap follows each step up or down
// - Reset gives normal spacing, no extension
// - PLL locks once 100 us have passed since enable
// - Memory clock equals reference or doubles it
`timescale 1ns/1ps
`default_nettype none
module mcdll_top
    import mcdll_pkg::*;
#(
    parameter int unsigned PLL_LOCK_CYC = PLL_LOCK_CYCLES
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fb_early,
    input  wire logic        pll_enable,
    input  wire logic        mem_ratio_2to1,
    output logic      [6:0]  tap_select,
    output logic             tap_spacing_max,
    output logic             dll_extend,
    output logic             dll_locked,
    output logic             pll_locked,
    output logic             ref_clk_en,
    output logic             mem_clk_en
);

    mcdll_top_st_t     st_r;
    mcdll_top_st_t     st_nxt;
    logic [SYNC_W-1:0] pins_in;
    logic [SYNC_W-1:0] pins_s;
    logic              fb_s;
    logic              pll_en_s;
    logic              ratio_s;
    logic              pll_lock_w;
    logic [7:0]        idx;
    logic              setup;
    logic              wr_done;
    logic [1:0]        mode;
    logic              mode_chg;

    // ****************************************************
    // Pin synchronisers and PLL timer
    // ****************************************************
    assign pins_in = {mem_ratio_2to1, pll_enable, fb_early};

    mcdll_sync u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pins_in   (pins_in),
        .pins_sync (pins_s)
    );

    assign fb_s     = pins_s[LANE_FB];
    assign pll_en_s = pins_s[LANE_PLL_EN];
    assign ratio_s  = pins_s[LANE_RATIO];

    mcdll_pll_timer #(
        .LOCK_CYC (PLL_LOCK_CYC)
    ) u_pll (
        .pclk       (pclk),
        .presetn    (presetn),
        .pll_enable (pll_en_s),
        .pll_locked (pll_lock_w)
    );

    // ****************************************************
    // Decode
    // ****************************************************
    assign idx      = paddr[9:2];
    assign setup    = psel && !penable;
    assign wr_done  = psel && penable && st_r.pready && pwrite;
    assign mode     = {st_r.spacing[MAX_DELAY_BIT],
                       st_r.pmc_two[EXTEND_BIT]};
    assign mode_chg = (mode != st_r.mode_prev);

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;

        // Read data latched in setup, so access always takes one cycle
        if (setup)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.rdata  = 8'h00;
            if (idx == IDX_PMC_TWO)
                st_nxt.rdata = st_r.pmc_two;
            else if (idx == IDX_SPACING)
                st_nxt.rdata = st_r.spacing;
            else if (idx == IDX_TAP_POS)
            begin
                st_nxt.rdata   = {1'b0, st_r.tap};
                st_nxt.pslverr = pwrite;
            end
            else if (idx == IDX_STATUS)
            begin
                st_nxt.rdata[STS_PLL_BIT]   = pll_lock_w;
                st_nxt.rdata[STS_DLL_BIT]   = st_r.locked;
                st_nxt.rdata[STS_RATIO_BIT] = st_r.ratio;
                st_nxt.pslverr = pwrite;
            end
            else
                st_nxt.pslverr = 1'b1;
        end

        if (wr_done)
        begin
            if (idx == IDX_PMC_TWO)
                st_nxt.pmc_two = pwdata[7:0];
            else if (idx == IDX_SPACING)
                st_nxt.spacing = pwdata[7:0];
        end

        // Strap follows the pin until the PLL locks, then freezes
        if (!pll_lock_w)
        begin
            st_nxt.ratio = ratio_s;
            st_nxt.phase = 2'h0;
        end
        else
            st_nxt.phase = st_r.phase + REF_PHASE_STEP;
        st_nxt.ref_en = pll_lock_w && (st_nxt.phase == REF_PHASE_LAST);
        st_nxt.mem_en = pll_lock_w &&
                        ((st_nxt.phase == REF_PHASE_LAST) ||
                         (st_r.ratio &&
                          st_nxt.phase == REF_PHASE_MID));

        // Any mode change voids the old lock: the tap spacing no longer fits
        st_nxt.mode_prev = mode;
        if (mode_chg || !pll_lock_w)
        begin
            st_nxt.tap    = TAP_MIN;
            st_nxt.locked = 1'b0;
            st_nxt.dir_up = 1'b1;
        end
        else if (st_r.mem_en)
        begin
            // A direction reversal means the edge has been bracketed
            st_nxt.dir_up = fb_s;
            if (fb_s != st_r.dir_up)
                st_nxt.locked = 1'b1;
            // Extension lets the search wrap instead of sticking
            if (fb_s)
            begin
                if (st_r.tap == TAP_MAX)
                    st_nxt.tap = mode[0] ? TAP_MIN : TAP_MAX;
                else
                    st_nxt.tap = st_r.tap + TAP_STEP;
            end
            else
            begin
                if (st_r.tap == TAP_MIN)
                    st_nxt.tap = mode[0] ? TAP_MAX : TAP_MIN;
                else
                    st_nxt.tap = st_r.tap - TAP_STEP;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r         <= '0;
            st_r.pmc_two <= PMC_TWO_RST;
            st_r.spacing <= SPACING_RST;
            st_r.dir_up  <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign prdata          = {24'h0000_00, st_r.rdata};
    assign pready          = st_r.pready;
    assign pslverr         = st_r.pslverr;
    assign tap_select      = st_r.tap;
    assign tap_spacing_max = st_r.spacing[MAX_DELAY_BIT];
    assign dll_extend      = st_r.pmc_two[EXTEND_BIT];
    assign dll_locked      = st_r.locked;
    assign pll_locked      = pll_lock_w;
    assign ref_clk_en      = st_r.ref_en;
    assign mem_clk_en      = st_r.mem_en;

    // ****************************************************
    // Checks
    // ****************************************************
    // One clock domain, so one default clocking serves every check
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    mode_write_a: assert property (wr_done && idx == IDX_PMC_TWO |=>
        dll_extend == $past(pwdata[EXTEND_BIT]))
        else $error("extend bit did not follow write");

    tap_sat_a: assert property (st_r.mem_en && pll_lock_w && fb_s &&
        !mode_chg && st_r.tap == TAP_MAX && !mode[0] |=> tap_select == TAP_MAX)
        else $error("tap left top without extension");

    tap_read_a: assert property (psel && penable && pready && !pwrite &&
        idx == IDX_TAP_POS |-> prdata == {25'h0, $past(st_r.tap)})
        else $error("tap read returned wrong value");

    tap_step_a: assert property (st_r.mem_en && pll_lock_w && fb_s &&
        !mode_chg && st_r.tap != TAP_MAX |=>
        tap_select == $past(st_r.tap) + TAP_STEP)
        else $error("tap did not step up");

    reset_mode_a: assert property (!$past(presetn) |->
        !dll_extend && !tap_spacing_max)
        else $error("mode not default after reset");

    ratio_mid_a: assert property (st_r.ratio && mem_clk_en &&
        !ref_clk_en |-> ##2 (ref_clk_en || !pll_locked))
        else $error("doubled memory edge misplaced");

    ref_mem_a: assert property (ref_clk_en |-> mem_clk_en)
        else $error("reference edge without memory edge");

    relock_a: assert property (mode_chg |=>
        tap_select == TAP_MIN && !dll_locked)
        else $error("mode change did not restart search");

    spc_write_a: assert property (wr_done && idx == IDX_SPACING |=>
        tap_spacing_max == $past(pwdata[MAX_DELAY_BIT]))
        else $error("spacing bit did not follow write");

    tap_down_a: assert property (st_r.mem_en && pll_lock_w &&
        !fb_s && !mode_chg && st_r.tap != TAP_MIN |=>
        tap_select == $past(st_r.tap) - TAP_STEP)
        else $error("tap did not step down");

    tap_wrap_a: assert property (st_r.mem_en && pll_lock_w &&
        fb_s && !mode_chg && st_r.tap == TAP_MAX && mode[0] |=>
        tap_select == TAP_MIN)
        else $error("tap did not wrap with extension");

    ro_write_a: assert property (psel && penable && pready &&
        pwrite && idx == IDX_TAP_POS |-> pslverr)
        else $error("write to tap position not refused");

    no_clk_a: assert property (!pll_lock_w |=>
        !mem_clk_en && !ref_clk_en && tap_select == TAP_MIN)
        else $error("memory clock ran without PLL lock");

    tap_hold_a: assert property (pll_lock_w && !st_r.mem_en &&
        !mode_chg |=> $stable(tap_select))
        else $error("tap moved between steps");

    ref_gap_a: assert property (ref_clk_en |=>
        !ref_clk_en ##1 !ref_clk_en ##1 !ref_clk_en)
        else $error("reference edges closer than four cycles");

    mem_one_a: assert property (!st_r.ratio |->
        mem_clk_en == ref_clk_en)
        else $error("extra memory edge in 1:1 mode");

    lock_rev_a: assert property (st_r.mem_en && pll_lock_w &&
        !mode_chg && fb_s != st_r.dir_up |=> dll_locked)
        else $error("reversal did not mark lock");

    status_rd_a: assert property (psel && penable && pready &&
        !pwrite && idx == IDX_STATUS |->
        prdata[STS_PLL_BIT] == $past(pll_lock_w))
        else $error("status read lost PLL lock bit");

    // ****************************************************
    // Covers
    // ****************************************************
    lock_seen_c: cover property (!dll_locked ##1 dll_locked);
    mode_chg_c:  cover property (pll_lock_w && mode_chg);
    tap_rd_c:    cover property (pready && !pwrite && idx == IDX_TAP_POS);
    wrap_c:      cover property (st_r.mem_en && mode[0] &&
                                 st_r.tap == TAP_MAX && fb_s);
    ratio_c:     cover property (st_r.ratio && mem_clk_en && !ref_clk_en);

endmodule
`default_nettype wire
